// ===== hw/iiera_controller.sv
// I2C bus controller end with a Wishbone register port
`timescale 1ns/1ps
`default_nettype none
module iiera_controller
  import iiera_pkg::*;
#(
  parameter int QTR = QTR_CYC
)
(
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Two-wire link
  iiera_if.controller bus
);
  iiera_ctl_state_t r;
  iiera_ctl_state_t n;
  logic tick;
  logic last;
  logic wr;

  if (QTR < 2 || QTR > 1023)
    $error("QTR out of range");

  assign tick = (r.div == 10'h000);
  assign last = r.idx | (r.len <= 2'h1);
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & r.ack;

  always_comb
  begin
    n = r;
    n.sda_s1 = bus.sda;
    n.sda_s2 = r.sda_s1;
    n.ack = wb_cyc_i & wb_stb_i & ~r.ack;
    if (wb_cyc_i & wb_stb_i & ~r.ack)
      unique case (wb_adr_i)
        WB_GO: n.dat = {22'h000000, r.len, r.rd, r.taddr};
        WB_SELECT: n.dat = {24'h000000, r.cmd};
        WB_WDATA: n.dat = {16'h0000, r.wdata};
        WB_RDATA: n.dat = {16'h0000, r.rdata};
        WB_STATUS: n.dat = {30'h00000000, r.nack, r.st != C_IDLE};
        default: n.dat = 32'h00000000;
      endcase
    if (wr && wb_adr_i == WB_SELECT && wb_sel_i[0])
      n.cmd = wb_dat_i[7:0];
    if (wr && wb_adr_i == WB_WDATA)
    begin
      if (wb_sel_i[0])
        n.wdata[7:0] = wb_dat_i[7:0];
      if (wb_sel_i[1])
        n.wdata[15:8] = wb_dat_i[15:8];
    end
    if (r.st == C_IDLE)
    begin
      if (wr && wb_adr_i == WB_GO && wb_sel_i[0])
      begin
        n.taddr = wb_dat_i[6:0];
        n.rd = wb_dat_i[7];
        if (wb_sel_i[1])
          n.len = wb_dat_i[9:8];
        n.st = C_START;
        n.q = 2'h0;
        n.bitn = 4'h0;
        n.nack = 1'b0;
        n.div = 10'(QTR - 1);
        n.sh = {wb_dat_i[6:0], 1'b0};
      end
    end
    else if (!tick)
      n.div = r.div - 10'h001;
    else
    begin
      n.div = 10'(QTR - 1);
      n.q = r.q + 2'h1;
      unique case (r.st)
        C_START, C_RSTA:
          unique case (r.q)
            2'h0: n.sda_oe_n = 1'b1;
            2'h1: n.scl_oe_n = 1'b1;
            2'h2: n.sda_oe_n = 1'b0;
            default:
            begin
              n.scl_oe_n = 1'b0;
              n.bitn = 4'h0;
              n.st = (r.st == C_START) ? C_ADDR : C_RADR;
            end
          endcase
        C_STOP:
          unique case (r.q)
            2'h0: n.sda_oe_n = 1'b0;
            2'h1: n.scl_oe_n = 1'b1;
            2'h2: n.sda_oe_n = 1'b1;
            default: n.st = C_IDLE;
          endcase
        default:
          unique case (r.q)
            2'h0:
              if (r.bitn != BYTE_BITS)
                n.sda_oe_n = (r.st == C_RDAT) ? 1'b1 : r.sh[7];
              else
                n.sda_oe_n = (r.st == C_RDAT) ? last : 1'b1;
            2'h1: n.scl_oe_n = 1'b1;
            2'h2:
              if (r.bitn != BYTE_BITS)
                n.sh = {r.sh[6:0], r.sda_s2};
              else if (r.st != C_RDAT)
                n.nack = r.sda_s2;
            default:
            begin
              n.scl_oe_n = 1'b0;
              if (r.bitn != BYTE_BITS)
                n.bitn = r.bitn + 4'h1;
              else
              begin
                n.bitn = 4'h0;
                if (r.st != C_RDAT && r.nack)
                  n.st = C_STOP;
                else
                  unique case (r.st)
                    C_ADDR:
                    begin
                      n.st = C_CMD;
                      n.sh = r.cmd;
                    end
                    C_CMD:
                      if (r.rd)
                      begin
                        n.st = C_RSTA;
                        n.sh = {r.taddr, 1'b1};
                      end
                      else if (r.len == 2'h0)
                        n.st = C_STOP;
                      else
                      begin
                        n.st = C_WDAT;
                        n.idx = 1'b0;
                        n.sh = r.wdata[7:0];
                      end
                    C_WDAT:
                      if (last)
                        n.st = C_STOP;
                      else
                      begin
                        n.idx = 1'b1;
                        n.sh = r.wdata[15:8];
                      end
                    C_RADR:
                    begin
                      n.st = C_RDAT;
                      n.idx = 1'b0;
                    end
                    default:
                    begin
                      if (r.idx)
                        n.rdata[15:8] = r.sh;
                      else
                        n.rdata[7:0] = r.sh;
                      n.idx = 1'b1;
                      if (last)
                        n.st = C_STOP;
                    end
                  endcase
              end
            end
          endcase
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      r <= '0;
      r.st <= C_IDLE;
      r.sda_s1 <= 1'b1;
      r.sda_s2 <= 1'b1;
      r.scl_oe_n <= 1'b1;
      r.sda_oe_n <= 1'b1;
    end
    else if (ce_i)
      r <= n;
  end

  assign bus.c_scl_o = 1'b0;
  assign bus.c_sda_o = 1'b0;
  assign bus.c_scl_oe_n = r.scl_oe_n;
  assign bus.c_sda_oe_n = r.sda_oe_n;
  assign wb_dat_o = r.dat;
  assign wb_ack_o = r.ack;
endmodule : iiera_controller
`default_nettype wire

// ===== hw/iiera_target.sv
// I2C target front end of the 16-bit I/O expander
// Functional notes
// - Write starts with address, direction bit 0
// - Ack selector, accept data until STOP
// - Read: write selector, restart, direction 1
// - Controller releases SDA, target drives data
// - Controller acks bytes wanting more data
// - Controller nacks last byte, then STOP
// - Restart keeps currently accessed register selected
// - Capture read data on ack rising edge
// - Further read bytes alternate within pair
// - Unlimited bytes per read transfer
// - STOP anywhere; last acked data stays
// - Address is fixed nibble plus straps
// - Address LSB one reads, zero writes
// - First write byte loads selector register
// - Only first write byte is selector
// - Selector persists; bit 0 flips each written byte and each acked read byte
// - Selector codes map eight registers
// - Input registers show pins, ignore writes
// - Output register reads return stored value
// - Invert bit flips reported input level
// - Direction bit one makes pin input
`timescale 1ns/1ps
`default_nettype none
module iiera_target
  import iiera_pkg::*;
(
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Two-wire link
  iiera_if.target bus,
  // Address straps
  input wire logic addr_strap_bit0_i,
  input wire logic addr_strap_bit1_i,
  input wire logic addr_strap_bit2_i,
  // Port pins
  input wire logic [15:0] pins_i,
  output logic [15:0] port_o,
  output logic [15:0] port_oe_n_o,
  // Control register view
  output logic [7:0] selector_o
);
  iiera_tgt_state_t r;
  iiera_tgt_state_t n;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic sda_v;

  // Register value seen by a read of selector code s
  function automatic logic [7:0] rd_val(input logic [2:0] s, input logic [15:0] pins,
                                        input logic [7:2][7:0] rg);
    if (s[2:1] == PAIR_INPUT)
      rd_val = s[0] ? (pins[15:8] ^ rg[5]) : (pins[7:0] ^ rg[4]);
    else
      rd_val = rg[s];
  endfunction : rd_val

  assign sda_v = r.sda_s[1];
  assign scl_rise = r.scl_s[1] & ~r.scl_s[2];
  assign scl_fall = ~r.scl_s[1] & r.scl_s[2];
  assign start_c = r.scl_s[1] & r.scl_s[2] & ~r.sda_s[1] & r.sda_s[2];
  assign stop_c = r.scl_s[1] & r.scl_s[2] & r.sda_s[1] & ~r.sda_s[2];

  always_comb
  begin
    n = r;
    n.scl_s = {r.scl_s[1:0], bus.scl};
    n.sda_s = {r.sda_s[1:0], bus.sda};
    n.pin_s1 = pins_i;
    n.pin_s2 = r.pin_s1;
    n.strap_s1 = {addr_strap_bit2_i, addr_strap_bit1_i, addr_strap_bit0_i};
    n.strap_s2 = r.strap_s1;
    if (start_c)
    begin
      n.st = T_ADDR;
      n.cnt = 4'h0;
      n.sda_oe_n = 1'b1;
    end
    else if (stop_c)
    begin
      n.st = T_IDLE;
      n.sda_oe_n = 1'b1;
    end
    else if (scl_rise)
    begin
      unique case (r.st)
        T_ADDR, T_CMD, T_WDAT:
        begin
          n.sh = {r.sh[6:0], sda_v};
          n.cnt = r.cnt + 4'h1;
        end
        T_AACK:
          if (r.rw)
            n.sh = rd_val(r.sel[2:0], r.pin_s2, r.regs);
        T_RACK:
        begin
          n.ack_ok = ~sda_v;
          if (~sda_v)
          begin
            n.sel[0] = ~r.sel[0];
            n.sh = rd_val({r.sel[2:1], ~r.sel[0]}, r.pin_s2, r.regs);
          end
        end
        default:
        begin
        end
      endcase
    end
    else if (scl_fall)
    begin
      unique case (r.st)
        T_ADDR:
          if (r.cnt == BYTE_BITS)
          begin
            if (r.sh[7:1] == {ADDR_HI, r.strap_s2})
            begin
              n.rw = r.sh[0];
              n.st = T_AACK;
              n.sda_oe_n = 1'b0;
            end
            else
              n.st = T_IDLE;
          end
        T_AACK:
        begin
          if (r.rw)
          begin
            n.st = T_RDAT;
            n.sda_oe_n = r.sh[7];
            n.sh = {r.sh[6:0], 1'b0};
            n.cnt = 4'h1;
          end
          else
          begin
            n.st = T_CMD;
            n.cnt = 4'h0;
            n.sda_oe_n = 1'b1;
          end
        end
        T_CMD:
          if (r.cnt == BYTE_BITS)
          begin
            n.sel = r.sh;
            n.st = T_CACK;
            n.sda_oe_n = 1'b0;
          end
        T_CACK, T_WACK:
        begin
          n.st = T_WDAT;
          n.cnt = 4'h0;
          n.sda_oe_n = 1'b1;
        end
        T_WDAT:
          if (r.cnt == BYTE_BITS)
          begin
            if (r.sel[2:1] != PAIR_INPUT)
              n.regs[r.sel[2:0]] = r.sh;
            n.sel[0] = ~r.sel[0];
            n.st = T_WACK;
            n.sda_oe_n = 1'b0;
          end
        T_RDAT:
          if (r.cnt == BYTE_BITS)
          begin
            n.st = T_RACK;
            n.sda_oe_n = 1'b1;
          end
          else
          begin
            n.sda_oe_n = r.sh[7];
            n.sh = {r.sh[6:0], 1'b0};
            n.cnt = r.cnt + 4'h1;
          end
        T_RACK:
          if (r.ack_ok)
          begin
            n.st = T_RDAT;
            n.sda_oe_n = r.sh[7];
            n.sh = {r.sh[6:0], 1'b0};
            n.cnt = 4'h1;
          end
          else
          begin
            n.st = T_IDLE;
            n.sda_oe_n = 1'b1;
          end
        default:
        begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      r <= '0;
      r.scl_s <= 3'h7;
      r.sda_s <= 3'h7;
      r.st <= T_IDLE;
      r.sel <= RST_SELECT;
      r.regs <= {RST_DIR, RST_DIR, RST_INVERT, RST_INVERT, RST_DRIVE, RST_DRIVE};
      r.sda_oe_n <= 1'b1;
    end
    else if (ce_i)
      r <= n;
  end

  assign bus.t_sda_o = 1'b0;
  assign bus.t_sda_oe_n = r.sda_oe_n;
  assign port_o = {r.regs[3], r.regs[2]};
  assign port_oe_n_o = {r.regs[7], r.regs[6]};
  assign selector_o = r.sel;
endmodule : iiera_target
`default_nettype wire

// ===== include/iiera_if.sv
// Two-wire link between expander target and bus controller
`timescale 1ns/1ps
`default_nettype none
interface iiera_if;
  logic c_scl_o;
  logic c_scl_oe_n;
  logic c_sda_o;
  logic c_sda_oe_n;
  logic t_sda_o;
  logic t_sda_oe_n;
  logic scl;
  logic sda;
  // Wired-AND lines with pull-up
  assign scl = ~(~c_scl_oe_n & ~c_scl_o);
  assign sda = ~((~c_sda_oe_n & ~c_sda_o) | (~t_sda_oe_n & ~t_sda_o));
  modport controller(output c_scl_o, c_scl_oe_n, c_sda_o, c_sda_oe_n, input scl, sda);
  modport target(output t_sda_o, t_sda_oe_n, input scl, sda);
endinterface : iiera_if
`default_nettype wire

// ===== include/iiera_pkg.sv
// Shared constants, state encodings and state records of the I2C expander link
package iiera_pkg;
  // Fixed upper nibble of the 7-bit target address
  localparam logic [3:0] ADDR_HI = 4'h4;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // Selector pair code of the input registers
  localparam logic [1:0] PAIR_INPUT = 2'h0;
  // Values after reset
  localparam logic [7:0] RST_DRIVE = 8'hFF;
  localparam logic [7:0] RST_INVERT = 8'h00;
  localparam logic [7:0] RST_DIR = 8'hFF;
  localparam logic [7:0] RST_SELECT = 8'h00;
  // Link timing: one SCL period is four quarters
  localparam int CLK_NS = 10;
  localparam int SCL_PERIOD_NS = 2500;
  localparam int QTR_CYC = (SCL_PERIOD_NS + 4 * CLK_NS - 1) / (4 * CLK_NS);
  // Controller register offsets on the Wishbone side
  localparam logic [7:0] WB_GO = 8'h00;
  localparam logic [7:0] WB_SELECT = 8'h04;
  localparam logic [7:0] WB_WDATA = 8'h08;
  localparam logic [7:0] WB_RDATA = 8'h0C;
  localparam logic [7:0] WB_STATUS = 8'h10;

  typedef enum logic [3:0] {
    T_IDLE = 4'h0, T_ADDR = 4'h1, T_AACK = 4'h2, T_CMD = 4'h3, T_CACK = 4'h4,
    T_WDAT = 4'h5, T_WACK = 4'h6, T_RDAT = 4'h7, T_RACK = 4'h8
  } iiera_tgt_st_t;

  typedef enum logic [3:0] {
    C_IDLE = 4'h0, C_START = 4'h1, C_ADDR = 4'h2, C_CMD = 4'h3, C_WDAT = 4'h4,
    C_RSTA = 4'h5, C_RADR = 4'h6, C_RDAT = 4'h7, C_STOP = 4'h8
  } iiera_ctl_st_t;

  typedef struct packed {
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic [15:0] pin_s1;
    logic [15:0] pin_s2;
    logic [2:0] strap_s1;
    logic [2:0] strap_s2;
    iiera_tgt_st_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rw;
    logic ack_ok;
    logic [7:0] sel;
    logic [7:2][7:0] regs;
    logic sda_oe_n;
  } iiera_tgt_state_t;

  typedef struct packed {
    iiera_ctl_st_t st;
    logic [1:0] q;
    logic [9:0] div;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic idx;
    logic [6:0] taddr;
    logic rd;
    logic [1:0] len;
    logic [7:0] cmd;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic nack;
    logic sda_s1;
    logic sda_s2;
    logic scl_oe_n;
    logic sda_oe_n;
    logic ack;
    logic [31:0] dat;
  } iiera_ctl_state_t;
endpackage : iiera_pkg

// ===== sim/iiera_sva.sv
// Checker of the link and register port of the I2C expander pair
`timescale 1ns/1ps
`default_nettype none
module iiera_sva (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Link signals
  input wire logic c_scl_o,
  input wire logic c_scl_oe_n,
  input wire logic c_sda_o,
  input wire logic c_sda_oe_n,
  input wire logic t_sda_o,
  input wire logic t_sda_oe_n,
  input wire logic scl,
  input wire logic sda,
  // Register port
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence start_s;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence stop_s;
    scl && $past(scl) && $rose(sda);
  endsequence
  ack_delay_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("register ack late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("register ack too long");
  drive_low_a: assert property (!c_scl_o && !c_sda_o && !t_sda_o)
    else $error("link drive value not low");
  tgt_hold_a: assert property ($fell(t_sda_oe_n) |-> !t_sda_oe_n [*8])
    else $error("target released line too early");
  tgt_edge_a: assert property (!$stable(t_sda_oe_n) |-> !scl)
    else $error("target changed data while clock high");
  stop_rel_a: assert property (stop_s |=> t_sda_oe_n [*4])
    else $error("target drives after stop");
  start_rel_a: assert property (start_s |=> t_sda_oe_n [*8])
    else $error("target drives during address");
  scl_high_a: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high phase short");
  scl_low_a: assert property ($fell(scl) |-> !scl [*8])
    else $error("clock low phase short");
  rst_rel_a: assert property ($fell(rst_i) |-> t_sda_oe_n && c_sda_oe_n && c_scl_oe_n)
    else $error("lines not released after reset");
  cover property (start_s);
  cover property (stop_s);
  cover property ($fell(t_sda_oe_n));
endmodule : iiera_sva
`default_nettype wire

// ===== sim/iiera_tb.sv
// Self-checking bench of the I2C expander target and controller pair
`timescale 1ns/1ps
`default_nettype none
module iiera_tb;
  import iiera_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic chk = 1'b0;
  logic [3:0] bsel = 4'hF;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic [2:0] strap = 3'h0;
  logic [15:0] pins = 16'h0000;
  logic [15:0] port;
  logic [15:0] port_oe_n;
  logic [7:0] sel;
  logic [31:0] exp_q[$];
  int n_fail = 0;
  int samples_checked = 0;
  iiera_if lnk();
  iiera_controller #(.QTR(8)) iiera_controller_inst (.clk_i(clk_i), .rst_i(rst_i),
    .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(bsel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .bus(lnk.controller));
  iiera_target iiera_target_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .bus(lnk.target), .addr_strap_bit0_i(strap[0]), .addr_strap_bit1_i(strap[1]),
    .addr_strap_bit2_i(strap[2]), .pins_i(pins), .port_o(port),
    .port_oe_n_o(port_oe_n), .selector_o(sel));
  iiera_sva iiera_sva_inst (.clk_i(clk_i), .rst_i(rst_i), .c_scl_o(lnk.c_scl_o),
    .c_scl_oe_n(lnk.c_scl_oe_n), .c_sda_o(lnk.c_sda_o), .c_sda_oe_n(lnk.c_sda_oe_n),
    .t_sda_o(lnk.t_sda_o), .t_sda_oe_n(lnk.t_sda_oe_n), .scl(lnk.scl), .sda(lnk.sda),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack));
  initial
  begin
    forever #5 clk_i = ~clk_i;
  end
  task automatic final_report();
    $display("Comparisons %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : cmp
  // One classic cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic c, output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    chk <= c;
    @(posedge clk_i);
    while (ack !== 1'b1)
      @(posedge clk_i);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    chk <= 1'b0;
  endtask : wb
  task automatic rd_exp(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    exp_q.push_back(e);
    wb(1'b0, a, 32'h0, 1'b1, q);
  endtask : rd_exp
  // Full link transfer, waits until idle
  task automatic run(input logic [7:0] go, input logic [1:0] len, input logic [7:0] cmd,
    input logic [15:0] d);
    logic [31:0] q;
    wb(1'b1, WB_SELECT, {24'h0, cmd}, 1'b0, q);
    wb(1'b1, WB_WDATA, {16'h0, d}, 1'b0, q);
    wb(1'b1, WB_GO, {22'h0, len, go}, 1'b0, q);
    q = 32'h1;
    while (q[0] !== 1'b0)
      wb(1'b0, WB_STATUS, 32'h0, 1'b0, q);
  endtask : run
  // Read results against the oldest note
  always @(posedge clk_i)
    if (ack === 1'b1 && chk === 1'b1 && exp_q.size() > 0)
      cmp("wb read", exp_q.pop_front(), rdat);
  initial
  begin
    repeat (60000) @(posedge clk_i);
    n_fail++;
    final_report();
  end
  initial
  begin
    logic [15:0] r;
    logic [15:0] inv;
    logic [15:0] p;
    logic [6:0] ta;
    void'($urandom(32'h3B99));
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    pins <= 16'($urandom);
    repeat (4) @(posedge clk_i);
    cmp("selector", {24'h0, RST_SELECT}, {24'h0, sel});
    cmp("port", {16'h0, RST_DRIVE, RST_DRIVE}, {16'h0, port});
    cmp("dir", {16'h0, RST_DIR, RST_DIR}, {16'h0, port_oe_n});
    rd_exp(8'h20, 32'h0);
    for (int s = 0; s < 8; s++)
    begin
      strap <= s[2:0];
      r = 16'($urandom);
      repeat (4) @(posedge clk_i);
      run({1'b0, ADDR_HI, s[2:0]}, 2'h1, 8'h02, r);
      cmp("port0", {24'h0, r[7:0]}, {24'h0, port[7:0]});
      cmp("selector", 32'h3, {24'h0, sel});
      run({1'b0, ADDR_HI, s[2:0] ^ 3'h1}, 2'h1, 8'h02, r);
      rd_exp(WB_STATUS, 32'h2);
    end
    ta = {ADDR_HI, 3'h7};
    inv = 16'h0;
    for (int c = 2; c < 8; c += 2)
    begin
      r = 16'($urandom);
      run({1'b0, ta}, 2'h2, c[7:0], r);
      run({1'b1, ta}, 2'h2, c[7:0], 16'h0);
      rd_exp(WB_RDATA, {16'h0, r});
      if (c == 2)
        cmp("port", {16'h0, r}, {16'h0, port});
      if (c == 4)
        inv = r;
      if (c == 6)
        cmp("dir", {16'h0, r}, {16'h0, port_oe_n});
    end
    run({1'b0, ta}, 2'h2, 8'h00, 16'($urandom));
    p = pins ^ inv;
    for (int c = 0; c < 2; c++)
    begin
      run({1'b1, ta}, 2'h2, c[7:0], 16'h0);
      if (c == 0)
        rd_exp(WB_RDATA, {16'h0, p});
      else
        rd_exp(WB_RDATA, {16'h0, p[7:0], p[15:8]});
      cmp("selector", {31'h0, ~c[0]}, {24'h0, sel});
    end
    rd_exp(WB_STATUS, 32'h0);
    @(posedge clk_i);
    cmp("pending reads", 32'h0, 32'(exp_q.size()));
    final_report();
  end
endmodule : iiera_tb
`default_nettype wire
